//--- hdl/bfs_regs.svh
`ifndef BFS_REGS_SVH
`define BFS_REGS_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define BFS_OFF_CTRL 8'h00
`define BFS_OFF_DUR 8'h04
`define BFS_OFF_STAT 8'h08

`define BFS_CTRL_PAT_LSB 0
`define BFS_CTRL_PAT_MSB 3
`define BFS_CTRL_MODE_LSB 4
`define BFS_CTRL_MODE_MSB 5
`define BFS_STAT_FLASHING 0
`define BFS_STAT_NIGHT 1
`define BFS_STAT_FAULT 2
`define BFS_STAT_CUTOFF 3
`define BFS_STAT_TRIG 4

// ****************************************************************
// Reset values and limits
// ****************************************************************
`define BFS_PAT_COUNT 4'hb
`define BFS_DUR_RST 12'h014
`define BFS_DUR_MIN 12'h005
`define BFS_DUR_MINUTE 12'h03c
`define BFS_DUR_MAX_MIN 12'h4b0
`define BFS_DUR_HOUR 12'he10

// ****************************************************************
// Timing
// ****************************************************************
`define BFS_CLK_NS 5
`define BFS_TICK_NS 10000000
`define BFS_TICK_CYC (`BFS_TICK_NS / `BFS_CLK_NS)
`define BFS_PH_LAST 7'h63
`define BFS_T_HALF 7'h32
`define BFS_T_QUART 7'h19
`define BFS_T_TENTH 7'h0a
`define BFS_T_QSLOT 7'h14
`define BFS_T_RAPID 7'h05
`define BFS_T_WWEND 7'h28
`define BFS_T_SIMEND 7'h50
`define BFS_DEB_TICKS 3'h3

`endif

//--- hdl/bfs_pkg.sv
package bfs_pkg;

   typedef enum logic [3:0] {
      bfs_pat_wigwag_sim = 4'h0,
      bfs_pat_wigwag_legacy = 4'h1,
      bfs_pat_rapid_circ = 4'h2,
      bfs_pat_uni_half = 4'h3,
      bfs_pat_alt_half = 4'h4,
      bfs_pat_three_alt = 4'h5,
      bfs_pat_uni_tenth = 4'h6,
      bfs_pat_uni_quart = 4'h7,
      bfs_pat_uni_quick = 4'h8,
      bfs_pat_alt_quick = 4'h9,
      bfs_pat_steady = 4'ha
   } bfs_pat_t;

   typedef enum logic [1:0] {
      bfs_mode_button = 2'h0,
      bfs_mode_open = 2'h1,
      bfs_mode_closed = 2'h2,
      bfs_mode_dusk = 2'h3
   } bfs_mode_t;

   typedef enum logic {
      bfs_st_dark = 1'b0,
      bfs_st_flash = 1'b1
   } bfs_st_t;

endpackage : bfs_pkg

//--- hdl/bfs_pin_filter.sv
`timescale 1ns/10ps
`include "bfs_regs.svh"

module bfs_pin_filter (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic tick,
   input wire logic pin_in,
   output logic level
);

   logic s1_r;
   logic s2_r;
   logic s3_r;
   logic [2:0] deb_r;
   logic [2:0] deb_nxt;
   logic level_nxt;

   wire agree = (s2_r == s3_r);
   wire differs = agree && (s3_r != level);
   wire settled = (deb_r == `BFS_DEB_TICKS);

   // Change is accepted only after it has stood for the debounce time
   assign deb_nxt = !differs ? 3'h0 :
                    (tick && !settled) ? deb_r + 3'h1 : deb_r;
   assign level_nxt = (differs && settled) ? s3_r : level;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
         s3_r <= 1'b0;
         deb_r <= 3'h0;
         level <= 1'b0;
      end else begin
         s1_r <= pin_in;
         s2_r <= s1_r;
         s3_r <= s2_r;
         deb_r <= deb_nxt;
         level <= level_nxt;
      end
   end

endmodule : bfs_pin_filter

//--- hdl/bfs_flash_sequencer.sv
// How it works
// - Eleven selectable flash patterns drive the two LED bank outputs
// - Unison half-second: both banks lit 0.5 s, once per second
// - Alternating half-second: banks take turns 0.5 s; reset default
// - Three-beacon alternate: 0.5 s turns, two-beacon bank then one
// - Short unison: both banks lit 0.1 s, once per second
// - Quarter unison: both banks lit 0.25 s, once per second
// - Unison quick flash: three 0.1 s pulses on both banks per second
// - Alternating quick flash: three 0.1 s pulses alternating banks
// - Steady: first bank continuously on, second bank off
// - One driver toggles two banks; alternating phases use other bank
// - Light-bar rapid pattern mixes wig-wag and simultaneous phases
// - Alternating with one fixture still drives bank two, flags fault
// - Button mode: brief short starts timed flashing; reset default
// - Normally-open mode: flash exactly while input is shorted
// - Normally-closed mode: flash always except while input shorted
// - Dusk mode: flash only while the sensor reports night
// - Duration accepts 5 to 60 s in 1 s steps
// - Duration accepts 60 to 1200 s in 60 s steps
// - Duration also accepts 3600 s
// - Duration resets to 20 s
// - Day/night flag from photosensor is kept for status display
// - LED fault clears when flashing next starts and wiring is good
// - Low-voltage cutoff blanks all banks and the digital output
`timescale 1ns/10ps
`include "bfs_regs.svh"

module bfs_flash_sequencer
   import bfs_pkg::*;
#(
   parameter int TICK_CYC = `BFS_TICK_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic trigger_short,
   input wire logic dark_sensor,
   input wire logic low_voltage_cutoff,
   input wire logic [1:0] bank_lit,
   output logic first_bank_output,
   output logic second_bank_output,
   output logic led_fault,
   output logic night_flag,
   output logic digital_out
);

   // ****************************************************************
   // Helper functions
   // ****************************************************************
   function automatic logic dur_ok(input logic [11:0] d);
      logic short_ok;
      logic long_ok;
      short_ok = (d >= `BFS_DUR_MIN) && (d <= `BFS_DUR_MINUTE);
      long_ok = (d >= `BFS_DUR_MINUTE) && (d <= `BFS_DUR_MAX_MIN)
                && ((d % `BFS_DUR_MINUTE) == 12'h000);
      dur_ok = short_ok || long_ok || (d == `BFS_DUR_HOUR);
   endfunction : dur_ok

   // Bank pair {second, first} for a pattern at a phase in ticks
   function automatic logic [1:0] pat_banks(input logic [3:0] pat,
                                            input logic [6:0] ph);
      logic fast_on;
      logic slot_b;
      logic quick_on;
      logic qodd;
      logic [6:0] qidx;
      fast_on = (ph % `BFS_T_TENTH) < `BFS_T_RAPID;
      slot_b = (ph % (`BFS_T_TENTH + `BFS_T_TENTH)) >= `BFS_T_TENTH;
      quick_on = (ph < `BFS_T_HALF) && ((ph % `BFS_T_QSLOT) < `BFS_T_TENTH);
      qidx = ph / `BFS_T_QSLOT;
      qodd = qidx[0];
      case (pat)
         bfs_pat_wigwag_sim: begin
            if (ph < `BFS_T_HALF) begin
               pat_banks = fast_on ? 2'h1 : 2'h2;
            end else begin
               pat_banks = fast_on ? 2'h3 : 2'h0;
            end
         end
         bfs_pat_wigwag_legacy: begin
            if (ph < `BFS_T_WWEND) begin
               pat_banks = slot_b ? 2'h2 : 2'h1;
            end else if (ph < `BFS_T_SIMEND) begin
               pat_banks = fast_on ? 2'h3 : 2'h0;
            end else begin
               pat_banks = 2'h0;
            end
         end
         bfs_pat_rapid_circ: begin
            if (ph < `BFS_T_HALF) begin
               pat_banks = fast_on ? 2'h1 : 2'h0;
            end else begin
               pat_banks = fast_on ? 2'h2 : 2'h0;
            end
         end
         bfs_pat_uni_half: begin
            pat_banks = (ph < `BFS_T_HALF) ? 2'h3 : 2'h0;
         end
         bfs_pat_alt_half, bfs_pat_three_alt: begin
            pat_banks = (ph < `BFS_T_HALF) ? 2'h1 : 2'h2;
         end
         bfs_pat_uni_tenth: begin
            pat_banks = (ph < `BFS_T_TENTH) ? 2'h3 : 2'h0;
         end
         bfs_pat_uni_quart: begin
            pat_banks = (ph < `BFS_T_QUART) ? 2'h3 : 2'h0;
         end
         bfs_pat_uni_quick: begin
            pat_banks = quick_on ? 2'h3 : 2'h0;
         end
         bfs_pat_alt_quick: begin
            pat_banks = !quick_on ? 2'h0 : (qodd ? 2'h2 : 2'h1);
         end
         bfs_pat_steady: begin
            pat_banks = 2'h1;
         end
         default: begin
            pat_banks = 2'h0;
         end
      endcase
   endfunction : pat_banks

   // ****************************************************************
   // Tick and input conditioning
   // ****************************************************************
   logic [23:0] tick_cnt_r;
   logic [23:0] tick_cnt_nxt;
   logic trig_lvl;
   logic night_lvl;

   wire tick = (tick_cnt_r == 24'(TICK_CYC - 1));
   assign tick_cnt_nxt = tick ? 24'h000000 : tick_cnt_r + 24'h000001;

   bfs_pin_filter u_trig_filter (
      .pclk(pclk),
      .presetn(presetn),
      .tick(tick),
      .pin_in(trigger_short),
      .level(trig_lvl)
   );

   bfs_pin_filter u_dark_filter (
      .pclk(pclk),
      .presetn(presetn),
      .tick(tick),
      .pin_in(dark_sensor),
      .level(night_lvl)
   );

   // ****************************************************************
   // Settings and APB decode
   // ****************************************************************
   logic [3:0] pat_r;
   logic [1:0] mode_r;
   logic [11:0] dur_r;
   logic [3:0] pat_nxt;
   logic [1:0] mode_nxt;
   logic [11:0] dur_nxt;
   logic [31:0] rd_mux;
   logic [31:0] prdata_nxt;
   logic fault_r;

   wire setup = psel && !penable;
   wire hit_ctrl = (paddr == `BFS_OFF_CTRL);
   wire hit_dur = (paddr == `BFS_OFF_DUR);
   wire hit_stat = (paddr == `BFS_OFF_STAT);
   wire mapped = hit_ctrl || hit_dur || hit_stat;
   wire [3:0] wr_pat = pwdata[`BFS_CTRL_PAT_MSB:`BFS_CTRL_PAT_LSB];
   wire [1:0] wr_mode = pwdata[`BFS_CTRL_MODE_MSB:`BFS_CTRL_MODE_LSB];
   wire [11:0] wr_dur = pwdata[11:0];
   wire pat_bad = (wr_pat >= `BFS_PAT_COUNT);
   wire dur_bad = !dur_ok(wr_dur) || (pwdata[31:12] != 20'h00000);
   wire wr_bad = (hit_ctrl && pat_bad) || (hit_dur && dur_bad) || hit_stat;
   wire err_nxt = setup && (!mapped || (pwrite && wr_bad));
   wire wr_go = psel && penable && pready && pwrite && !pslverr;
   wire wr_ctrl = wr_go && hit_ctrl;
   wire wr_dur_go = wr_go && hit_dur;

   assign pat_nxt = wr_ctrl ? wr_pat : pat_r;
   assign mode_nxt = wr_ctrl ? wr_mode : mode_r;
   assign dur_nxt = wr_dur_go ? wr_dur : dur_r;

   // ****************************************************************
   // Activation and duration
   // ****************************************************************
   bfs_st_t st_r;
   bfs_st_t st_nxt;
   logic trig_q_r;
   logic [11:0] remain_r;
   logic [11:0] remain_nxt;
   logic [6:0] phase_r;
   logic [6:0] phase_nxt;
   logic want;

   wire is_button = (mode_r == bfs_mode_button);
   // A held contact counts once: only its filtered rising edge reloads
   wire press = trig_lvl && !trig_q_r && is_button;
   wire sec_end = tick && (phase_r == `BFS_PH_LAST);

   always_comb begin
      case (mode_r)
         bfs_mode_button: want = (remain_r != 12'h000);
         bfs_mode_open: want = trig_lvl;
         bfs_mode_closed: want = !trig_lvl;
         bfs_mode_dusk: want = night_lvl;
         default: want = 1'b0;
      endcase
   end

   wire run = want && !low_voltage_cutoff;
   wire begin_flash = (st_r == bfs_st_dark) && run;
   wire restart = begin_flash || (press && st_r == bfs_st_flash);

   always_comb begin
      case (st_r)
         bfs_st_dark: st_nxt = run ? bfs_st_flash : bfs_st_dark;
         bfs_st_flash: st_nxt = run ? bfs_st_flash : bfs_st_dark;
         default: st_nxt = bfs_st_dark;
      endcase
   end

   assign remain_nxt = press ? dur_r :
                       (sec_end && remain_r != 12'h000) ?
                       remain_r - 12'h001 : remain_r;
   // Each flashing period opens on the first pulse of its pattern
   assign phase_nxt = restart ? 7'h00 :
                      !tick ? phase_r :
                      (phase_r == `BFS_PH_LAST) ? 7'h00 :
                      phase_r + 7'h01;

   // ****************************************************************
   // Bank drive and fault check
   // ****************************************************************
   logic [1:0] banks_nxt;
   logic [1:0] held_r;
   logic fault_nxt;

   wire flashing = (st_r == bfs_st_flash) && !low_voltage_cutoff;
   wire [1:0] bank_now = {second_bank_output, first_bank_output};

   assign banks_nxt = (flashing && !restart) ?
                      pat_banks(pat_r, phase_r) : 2'h0;
   // A bank driven for a full tick with no current means open or short
   wire fault_set = tick && |(bank_now & held_r & ~bank_lit);
   // Set wins when a new fault and a fresh start fall in one clock
   assign fault_nxt = fault_set || (led_fault && !begin_flash);

   // ****************************************************************
   // Read back
   // ****************************************************************
   // Status bits are placed by field position so the map lives in
   // one header; the status word is read only
   logic [31:0] ctrl_word;
   logic [31:0] dur_word;
   logic [31:0] stat_word;

   assign ctrl_word = {26'h0000000, mode_r, pat_r};
   assign dur_word = {20'h00000, dur_r};

   always_comb begin
      stat_word = 32'h00000000;
      stat_word[`BFS_STAT_FLASHING] = flashing;
      stat_word[`BFS_STAT_NIGHT] = night_flag;
      stat_word[`BFS_STAT_FAULT] = led_fault;
      stat_word[`BFS_STAT_CUTOFF] = low_voltage_cutoff;
      stat_word[`BFS_STAT_TRIG] = trig_lvl;
   end

   assign rd_mux = hit_ctrl ? ctrl_word :
                   hit_dur ? dur_word :
                   hit_stat ? stat_word :
                   32'h00000000;
   assign prdata_nxt = (setup && !pwrite) ? rd_mux : 32'h00000000;

   // ****************************************************************
   // Registers
   // ****************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else begin
         // Zero wait states: every access phase is answered at once
         pready <= setup;
         pslverr <= err_nxt;
         prdata <= prdata_nxt;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pat_r <= bfs_pat_alt_half;
         mode_r <= bfs_mode_button;
         dur_r <= `BFS_DUR_RST;
      end else begin
         pat_r <= pat_nxt;
         mode_r <= mode_nxt;
         dur_r <= dur_nxt;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_cnt_r <= 24'h000000;
         st_r <= bfs_st_dark;
         trig_q_r <= 1'b0;
         remain_r <= 12'h000;
         phase_r <= 7'h00;
      end else begin
         tick_cnt_r <= tick_cnt_nxt;
         st_r <= st_nxt;
         trig_q_r <= trig_lvl;
         remain_r <= remain_nxt;
         phase_r <= phase_nxt;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         first_bank_output <= 1'b0;
         second_bank_output <= 1'b0;
         held_r <= 2'h0;
         led_fault <= 1'b0;
         night_flag <= 1'b0;
         digital_out <= 1'b0;
      end else begin
         first_bank_output <= banks_nxt[0];
         second_bank_output <= banks_nxt[1];
         held_r <= tick ? bank_now : held_r;
         led_fault <= fault_nxt;
         night_flag <= night_lvl;
         digital_out <= flashing;
      end
   end

endmodule : bfs_flash_sequencer

//--- dv/bfs_flash_sequencer_props.sv
`timescale 1ns/10ps
`include "bfs_regs.svh"
module bfs_flash_sequencer_props
   import bfs_pkg::*;
#(
   parameter int TICK_CYC = 4
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic trigger_short,
   input wire logic dark_sensor,
   input wire logic low_voltage_cutoff,
   input wire logic [1:0] bank_lit,
   input wire logic first_bank_output,
   input wire logic second_bank_output,
   input wire logic led_fault,
   input wire logic night_flag,
   input wire logic digital_out
);
   logic [3:0] pat_q, pat_d, pat_dd;
   logic hold, dead;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   function automatic logic dur_ok(input logic [31:0] v);
      return v inside {[5:60], 3600} || v % 60 == 0 && v inside {[60:1200]};
   endfunction : dur_ok
   // Pattern as last accepted, aged two clocks to skip the changeover
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pat_q <= 4'h4;
         pat_d <= 4'h4;
         pat_dd <= 4'h4;
      end else begin
         if (psel && penable && pready && pwrite && !pslverr &&
             paddr == `BFS_OFF_CTRL) begin
            pat_q <= pwdata[3:0];
         end
         pat_d <= pat_q;
         pat_dd <= pat_d;
      end
   end
   assign hold = digital_out && pat_q == pat_d && pat_d == pat_dd;
   assign dead = first_bank_output && !bank_lit[0] ||
                 second_bank_output && !bank_lit[1];
   a_ready_next: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready held");
   a_bad_addr: assert property (psel && !penable && !(paddr inside
      {`BFS_OFF_CTRL, `BFS_OFF_DUR, `BFS_OFF_STAT}) |=> pslverr)
      else $error("unmapped access accepted");
   a_dur_check: assert property (
      psel && !penable && pwrite && paddr == `BFS_OFF_DUR
      |=> pslverr == !dur_ok($past(pwdata))) else $error("bad duration");
   a_cutoff_blank: assert property (
      low_voltage_cutoff |=> !first_bank_output && !second_bank_output
      && !digital_out) else $error("lit in cutoff");
   a_unison_same: assert property (
      hold && pat_q inside {4'h3, 4'h6, 4'h7, 4'h8}
      |-> first_bank_output == second_bank_output) else $error("not unison");
   a_alt_apart: assert property (
      hold && pat_q inside {4'h4, 4'h5, 4'h9}
      |-> !(first_bank_output && second_bank_output)) else $error("both on");
   a_steady_first: assert property (
      hold && pat_q == 4'ha |-> first_bank_output && !second_bank_output)
      else $error("steady wrong");
   a_night_cause: assert property (
      $rose(night_flag) |-> $past(dark_sensor, 8)) else $error("night early");
   a_fault_cause: assert property (
      $rose(led_fault) |-> $past(dead)) else $error("fault no cause");
endmodule : bfs_flash_sequencer_props

//--- dv/bfs_contact_model.sv
`timescale 1ns/10ps
module bfs_contact_model (
   input wire logic pclk,
   input wire logic closed,
   output logic contact_short
);
   logic [3:0] bnc_r = 4'h0;
   logic last_r = 1'b0;
   // Contact chatters for a few clocks after every change
   always @(posedge pclk) begin
      if (closed != last_r) bnc_r <= 4'h7;
      else if (bnc_r != 4'h0) bnc_r <= bnc_r - 4'h1;
      last_r <= closed;
   end
   assign contact_short = (bnc_r != 4'h0) ? bnc_r[0] : closed;
endmodule : bfs_contact_model

//--- dv/bfs_flash_sequencer_tb.sv
`timescale 1ns/10ps
`include "bfs_regs.svh"
module bfs_flash_sequencer_tb;
   import bfs_pkg::*;
   localparam int TK = 4;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rv;
   logic pready, pslverr, led_fault, night_flag, digital_out;
   logic first_bank_output, second_bank_output, trigger_short;
   logic press = 0, dark_sensor = 0, low_voltage_cutoff = 0, meas_v = 0;
   logic [1:0] fix_mask = 2'h3, bank_lit;
   logic [32:0] meas_r = 0;
   logic [33:0] q[$];
   int bad_count = 0, check_count = 0;
   int dv[10] = '{4, 5, 60, 61, 120, 1200, 1260, 3599, 3600, 'h1005};
   int pt[11] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10};
   int b1[11] = '{50, 40, 25, 50, 50, 50, 10, 25, 30, 20, 100};
   int b2[11] = '{50, 40, 25, 50, 50, 50, 10, 25, 30, 10, 0};
   always #2.5 pclk = ~pclk;
   assign bank_lit = {second_bank_output, first_bank_output} & fix_mask;
   bfs_contact_model bfs_contact_model_inst (.pclk(pclk), .closed(press),
      .contact_short(trigger_short));
   bfs_flash_sequencer #(.TICK_CYC(TK)) bfs_flash_sequencer_inst (.pclk,
      .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .trigger_short, .dark_sensor, .low_voltage_cutoff, .bank_lit,
      .first_bank_output, .second_bank_output, .led_fault, .night_flag,
      .digital_out);
   task automatic print_verdict();
      if (bad_count == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : print_verdict
   task automatic cmp(input logic [32:0] got);
      logic [33:0] e;
      e = q.size() ? q.pop_front() : '1;
      check_count++;
      if (e[33] ? got !== e[32:0] : got[32] !== e[32]) begin
         bad_count++;
         $display("unexpected at %0t: got %h want %h", $time, got, e[32:0]);
      end
   endtask : cmp
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1) cmp({pslverr, prdata});
      if (meas_v) cmp(meas_r);
   end
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [33:0] e);
      q.push_back(e);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic r);
      apb(1'b1, a, d, {1'b0, r, 32'h0});
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] d);
      apb(1'b0, a, 32'h0, {1'b1, a == 8'h0c, d});
   endtask : rd
   function automatic logic dur_bad(input logic [31:0] v);
      return !(v inside {[5:60], 3600} ||
               v % 60 == 0 && v inside {[60:1200]});
   endfunction : dur_bad
   task automatic meas(input int e1, input int e2);
      int c1, c2;
      c1 = 0;
      c2 = 0;
      q.push_back({2'b10, 16'(e1 * TK), 16'(e2 * TK)});
      repeat (100 * TK) begin
         @(posedge pclk);
         c1 += int'(first_bank_output === 1'b1);
         c2 += int'(second_bank_output === 1'b1);
      end
      meas_r <= {1'b0, 16'(c1), 16'(c2)};
      meas_v <= 1'b1;
      @(posedge pclk);
      meas_v <= 1'b0;
   endtask : meas
   task automatic hold_for(input logic p);
      press <= p;
      repeat (40) @(posedge pclk);
   endtask : hold_for
   initial begin
      #(40000 * 5);
      bad_count++;
      print_verdict();
   end
   initial begin
      void'($urandom(32'h3e50afea));
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      rd(`BFS_OFF_CTRL, 32'h4);
      rd(`BFS_OFF_DUR, 32'd20);
      rd(8'h0c, 32'h0);
      wr(`BFS_OFF_STAT, 32'h1, 1'b1);
      wr(`BFS_OFF_CTRL, 32'hb, 1'b1);
      foreach (dv[i]) wr(`BFS_OFF_DUR, dv[i], dur_bad(dv[i]));
      repeat (6) begin
         rv = $urandom % 4096;
         wr(`BFS_OFF_DUR, rv, dur_bad(rv));
      end
      wr(`BFS_OFF_DUR, 32'd5, 1'b0);
      for (int i = 0; i < 11; i++) wr(`BFS_OFF_CTRL, 32'h20 | i, 1'b0);
      foreach (pt[i]) begin
         wr(`BFS_OFF_CTRL, 32'h20 | pt[i], 1'b0);
         repeat (5) @(posedge pclk);
         meas(b1[i], b2[i]);
      end
      low_voltage_cutoff <= 1'b1;
      @(posedge pclk);
      meas(0, 0);
      low_voltage_cutoff <= 1'b0;
      hold_for(1'b1);
      rd(`BFS_OFF_STAT, 32'h10);
      hold_for(1'b0);
      rd(`BFS_OFF_STAT, 32'h1);
      wr(`BFS_OFF_CTRL, 32'h14, 1'b0);
      rd(`BFS_OFF_STAT, 32'h0);
      hold_for(1'b1);
      rd(`BFS_OFF_STAT, 32'h11);
      hold_for(1'b0);
      wr(`BFS_OFF_CTRL, 32'h34, 1'b0);
      dark_sensor <= 1'b1;
      repeat (40) @(posedge pclk);
      rd(`BFS_OFF_STAT, 32'h3);
      dark_sensor <= 1'b0;
      repeat (40) @(posedge pclk);
      rd(`BFS_OFF_STAT, 32'h0);
      wr(`BFS_OFF_CTRL, 32'h4, 1'b0);
      fix_mask <= 2'h1;
      hold_for(1'b1);
      hold_for(1'b0);
      repeat (1000) @(posedge pclk);
      rd(`BFS_OFF_STAT, 32'h5);
      hold_for(1'b1);
      hold_for(1'b0);
      repeat (1400) @(posedge pclk);
      rd(`BFS_OFF_STAT, 32'h5);
      repeat (1000) @(posedge pclk);
      rd(`BFS_OFF_STAT, 32'h4);
      fix_mask <= 2'h3;
      hold_for(1'b1);
      hold_for(1'b0);
      rd(`BFS_OFF_STAT, 32'h1);
      repeat (2200) @(posedge pclk);
      rd(`BFS_OFF_STAT, 32'h0);
      print_verdict();
   end
endmodule : bfs_flash_sequencer_tb
bind bfs_flash_sequencer bfs_flash_sequencer_props #(.TICK_CYC(TICK_CYC))
   bfs_flash_sequencer_props_inst (.pclk, .presetn, .psel, .penable, .pwrite,
   .paddr, .pwdata, .prdata, .pready, .pslverr, .trigger_short, .dark_sensor,
   .low_voltage_cutoff, .bank_lit, .first_bank_output, .second_bank_output,
   .led_fault, .night_flag, .digital_out);
